// ==== hdl/cmp_channel.v ====
// Purpose: one comparator channel: control register, result path, events
// Assumes: raw result already synchronised; 16-bit register writes
// Notes:   the sticky flag only clears by reset or by a write of zero to its bit
`include "cmp_event_map.vh"
module cmp_channel
(
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        wr_in,
  input  wire [15:0] wdata_in,
  input  wire        run_in,
  input  wire        raw_in,
  output wire [15:0] ctrl_out,
  output wire        result_out,
  output wire        event_out,
  output wire        pin_out,
  output wire        pin_oe_n_out,
  output wire        on_out,
  output wire        trig_out,
  output wire        pos_ref_out,
  output wire [1:0]  neg_sel_out
);
  reg        channel_on_q;
  reg        pin_drive_enable_q;
  reg        result_invert_q;
  reg        sticky_event_flag_q;
  reg [1:0]  edge_select_q;
  reg        positive_ref_select_q;
  reg [1:0]  negative_input_select_q;
  reg        result_q;
  reg        result_d;
  reg        prev_q;
  reg        prime_q;
  reg        hit;
  reg        trig_q;
  wire       active;

  assign active = channel_on_q & run_in;

  always @*
  begin
    result_d = result_q;
    if (active)
      result_d = raw_in ^ result_invert_q;
  end

  always @*
  begin
    case (edge_select_q)
      `CMP_EDGE_RISE: hit = ~prev_q & result_q;
      `CMP_EDGE_FALL: hit = prev_q & ~result_q;
      `CMP_EDGE_ANY:  hit = prev_q ^ result_q;
      default:        hit = 1'b0;
    endcase
    hit = hit & active & prime_q & ~sticky_event_flag_q;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      channel_on_q            <= 1'b0;
      pin_drive_enable_q      <= 1'b0;
      result_invert_q         <= 1'b0;
      sticky_event_flag_q     <= 1'b0;
      edge_select_q           <= `CMP_EDGE_NONE;
      positive_ref_select_q   <= 1'b0;
      negative_input_select_q <= `CMP_NSEL_B;
      result_q                <= 1'b0;
      prev_q                  <= 1'b0;
      prime_q                 <= 1'b0;
      trig_q                  <= 1'b0;
    end
    else
    begin
      result_q <= result_d;
      prev_q   <= result_q;
      prime_q  <= active;
      trig_q   <= hit;
      if (wr_in)
      begin
        channel_on_q            <= wdata_in[`CMP_CTL_ON_BIT];
        pin_drive_enable_q      <= wdata_in[`CMP_CTL_OE_BIT];
        result_invert_q         <= wdata_in[`CMP_CTL_INV_BIT];
        edge_select_q           <= wdata_in[`CMP_CTL_EDGE_HI:`CMP_CTL_EDGE_LO];
        positive_ref_select_q   <= wdata_in[`CMP_CTL_REF_BIT];
        negative_input_select_q <= wdata_in[`CMP_CTL_NSEL_HI:`CMP_CTL_NSEL_LO];
      end
      // set wins over a clearing write in the same cycle
      if (hit)
        sticky_event_flag_q <= 1'b1;
      else if (wr_in && !wdata_in[`CMP_CTL_EVT_BIT])
        sticky_event_flag_q <= 1'b0;
    end
  end

  assign ctrl_out = {channel_on_q, pin_drive_enable_q, result_invert_q,
                     3'h0, sticky_event_flag_q, result_q,
                     edge_select_q, 1'b0, positive_ref_select_q,
                     2'h0, negative_input_select_q};
  assign result_out   = result_q;
  assign event_out    = sticky_event_flag_q;
  assign pin_out      = result_q & pin_drive_enable_q;
  assign pin_oe_n_out = ~(pin_drive_enable_q & channel_on_q);
  assign on_out       = active;
  assign trig_out     = trig_q;
  assign pos_ref_out  = positive_ref_select_q;
  assign neg_sel_out  = negative_input_select_q;
endmodule // cmp_channel

// ==== hdl/cmp_event_map.vh ====
// Purpose: register offsets, field positions and reset values for the
//          three-channel comparator control and status block
// Assumes: 16-bit registers on a plain address/strobe port
// Notes:   offsets are word indices on the register port
`ifndef CMP_EVENT_MAP_VH
`define CMP_EVENT_MAP_VH
`define CMP_ADDR_W        2
`define CMP_OFS_STATUS    2'h0
`define CMP_OFS_CTRL1     2'h1
`define CMP_OFS_CTRL2     2'h2
`define CMP_OFS_CTRL3     2'h3
`define CMP_STAT_IDLE_BIT 15
`define CMP_STAT_EVT_LSB  8
`define CMP_STAT_RES_LSB  0
`define CMP_CTL_ON_BIT    15
`define CMP_CTL_OE_BIT    14
`define CMP_CTL_INV_BIT   13
`define CMP_CTL_EVT_BIT   9
`define CMP_CTL_RES_BIT   8
`define CMP_CTL_EDGE_HI   7
`define CMP_CTL_EDGE_LO   6
`define CMP_CTL_REF_BIT   4
`define CMP_CTL_NSEL_HI   1
`define CMP_CTL_NSEL_LO   0
`define CMP_CTL_RESET     16'h0000
`define CMP_STAT_RESET    1'b0
`define CMP_EDGE_NONE     2'b00
`define CMP_EDGE_RISE     2'b01
`define CMP_EDGE_FALL     2'b10
`define CMP_EDGE_ANY      2'b11
`define CMP_NSEL_B        2'b00
`define CMP_NSEL_C        2'b01
`define CMP_NSEL_D        2'b10
`define CMP_NSEL_REF      2'b11
`endif

// ==== hdl/cmp_sync2.v ====
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: single clock, synchronous active-high reset
// Notes:   the first stage is read only by the second
module cmp_sync2
(
  input  wire clk_in,
  input  wire rst_in,
  input  wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // cmp_sync2

// ==== hdl/cmp_event_top.v ====
// Purpose: three-channel comparator control and status block
// Assumes: analog cores outside; raw results asynchronous
// Notes:   read data appear one cycle after the read strobe
`include "cmp_event_map.vh"
module cmp_event_top
(
  input  wire                   CORE_CLK_IN,
  input  wire                   RESET_IN,
  input  wire [`CMP_ADDR_W-1:0] ADDR_IN,
  input  wire [15:0]            WDATA_IN,
  input  wire                   WR_IN,
  input  wire                   RD_IN,
  output wire [15:0]            RDATA_OUT,
  input  wire                   IDLE_IN,
  input  wire [2:0]             RAW_RESULT_IN,
  output wire [2:0]             CMP_ENABLE_OUT,
  output wire [2:0]             POS_REF_SELECT_OUT,
  output wire [5:0]             NEG_INPUT_SELECT_OUT,
  output wire [2:0]             RESULT_PIN_OUT,
  output wire [2:0]             RESULT_PIN_OE_N_OUT,
  output wire [2:0]             TRIGGER_OUT
);
  reg         idle_stop_all_q;
  reg  [15:0] rdata_q;
  reg  [15:0] rdata_d;
  wire        run;
  wire [2:0]  raw_sync;
  wire [2:0]  result;
  wire [2:0]  evt;
  wire [47:0] ctrl;
  wire [15:0] status;

  assign run = ~(idle_stop_all_q & IDLE_IN);

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : chan
      cmp_sync2 u_sync
      (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .async_in (RAW_RESULT_IN[g]),
        .sync_out (raw_sync[g])
      );
      cmp_channel u_chan
      (
        .clk_in       (CORE_CLK_IN),
        .rst_in       (RESET_IN),
        .wr_in        (WR_IN && ADDR_IN == g + 1),
        .wdata_in     (WDATA_IN),
        .run_in       (run),
        .raw_in       (raw_sync[g]),
        .ctrl_out     (ctrl[16*g+15:16*g]),
        .result_out   (result[g]),
        .event_out    (evt[g]),
        .pin_out      (RESULT_PIN_OUT[g]),
        .pin_oe_n_out (RESULT_PIN_OE_N_OUT[g]),
        .on_out       (CMP_ENABLE_OUT[g]),
        .trig_out     (TRIGGER_OUT[g]),
        .pos_ref_out  (POS_REF_SELECT_OUT[g]),
        .neg_sel_out  (NEG_INPUT_SELECT_OUT[2*g+1:2*g])
      );
    end
  endgenerate

  // bits 14-11 and 7-3 tie to zero
  assign status = {idle_stop_all_q, 4'h0, evt, 5'h00, result};

  always @*
  begin
    case (ADDR_IN)
      `CMP_OFS_STATUS: rdata_d = status;
      `CMP_OFS_CTRL1:  rdata_d = ctrl[15:0];
      `CMP_OFS_CTRL2:  rdata_d = ctrl[31:16];
      `CMP_OFS_CTRL3:  rdata_d = ctrl[47:32];
      default:         rdata_d = 16'h0000;
    endcase
  end

  always @(posedge CORE_CLK_IN)
  begin
    if (RESET_IN)
    begin
      idle_stop_all_q <= `CMP_STAT_RESET;
      rdata_q         <= 16'h0000;
    end
    else
    begin
      if (WR_IN && ADDR_IN == `CMP_OFS_STATUS)
        idle_stop_all_q <= WDATA_IN[`CMP_STAT_IDLE_BIT];
      rdata_q <= RD_IN ? rdata_d : 16'h0000;
    end
  end

  assign RDATA_OUT = rdata_q;
endmodule // cmp_event_top

// ==== verification/cmp_analog_model.sv ====
// Purpose: analog comparator cores on the far side of the block
// Assumes: pin levels a, b, c, d arrive as nibbles of lvl_in
// Notes:   a core that is off gives a toggling, meaningless result
module cmp_analog_model
(
  input  logic        clk_in,
  input  logic [2:0]  en_in,
  input  logic [2:0]  pref_in,
  input  logic [5:0]  nsel_in,
  input  logic [15:0] lvl_in,
  output logic [2:0]  raw_out
);
  logic t_q = 1'b0;
  function automatic logic [3:0] v(input logic [2:0] s);
    return s[2] ? 4'h8 : lvl_in[4*s[1:0] +: 4];
  endfunction
  always @(posedge clk_in)
    t_q <= ~t_q;
  always_comb
    for (int i = 0; i < 3; i++)
      raw_out[i] = !en_in[i] ? t_q :
        v({pref_in[i], 2'b00}) >
        v(nsel_in[2*i +: 2] == 2'h3 ? 3'h4 :
          {1'b0, nsel_in[2*i +: 2] + 2'h1});
endmodule // cmp_analog_model

// ==== verification/cmp_event_sva.sv ====
// Purpose: port checks for the comparator control and status block
// Assumes: one clock, synchronous active-high reset
// Notes:   event flags are tracked from trigger pulses and writes
`include "cmp_event_map.vh"
module cmp_event_sva
(
  input logic                   CORE_CLK_IN,
  input logic                   RESET_IN,
  input logic [`CMP_ADDR_W-1:0] ADDR_IN,
  input logic [15:0]            WDATA_IN,
  input logic                   WR_IN,
  input logic                   RD_IN,
  input logic [15:0]            RDATA_OUT,
  input logic                   IDLE_IN,
  input logic [2:0]             CMP_ENABLE_OUT,
  input logic [2:0]             RESULT_PIN_OUT,
  input logic [2:0]             RESULT_PIN_OE_N_OUT,
  input logic [2:0]             TRIGGER_OUT
);
  logic [2:0] on_q, oe_q, flg_q, nz, flg_now;
  logic [5:0] edg_q;
  logic       stop_q;
  assign nz = {|edg_q[5:4], |edg_q[3:2], |edg_q[1:0]};
  // a flag reads set from the cycle in which its trigger pulse stands
  assign flg_now = flg_q | TRIGGER_OUT;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  always @(posedge CORE_CLK_IN)
    if (RESET_IN)
    begin
      {on_q, oe_q, flg_q, edg_q, stop_q} <= 16'h0000;
    end
    else
    begin
      if (WR_IN && ADDR_IN == 2'h0)
        stop_q <= WDATA_IN[15];
      for (int i = 0; i < 3; i++)
      begin
        if (WR_IN && ADDR_IN == i + 1)
        begin
          on_q[i] <= WDATA_IN[15];
          oe_q[i] <= WDATA_IN[14];
          edg_q[2*i +: 2] <= WDATA_IN[7:6];
        end
        // flag state without a trigger that rises in the coming cycle
        flg_q[i] <= flg_now[i]
          & ~(WR_IN && ADDR_IN == i + 1 && !WDATA_IN[9]);
      end
    end
  en_map_a: assert property (
    $stable(IDLE_IN) |-> CMP_ENABLE_OUT == (on_q & ~{3{IDLE_IN & stop_q}}))
    else $error("enable mismatch");
  oe_pin_a: assert property (
    RESULT_PIN_OE_N_OUT == ~(oe_q & on_q)) else $error("pin enable wrong");
  pin_off_a: assert property (
    (RESULT_PIN_OUT & ~oe_q & ~$past(oe_q)) == 3'h0)
    else $error("pin driven while off");
  trig_pulse_a: assert property (
    (TRIGGER_OUT & $past(TRIGGER_OUT)) == 3'h0) else $error("long trigger");
  flag_block_a: assert property (
    (TRIGGER_OUT & flg_q) == 3'h0) else $error("trigger while flagged");
  no_edge_a: assert property (
    (TRIGGER_OUT & ~nz & ~$past(nz) & ~$past(nz, 2)) == 3'h0)
    else $error("trigger with edge select off");
  run_gate_a: assert property (
    (TRIGGER_OUT & ~CMP_ENABLE_OUT & ~$past(CMP_ENABLE_OUT)
      & ~$past(CMP_ENABLE_OUT, 2)) == 3'h0) else $error("trigger while off");
  stat_zero_a: assert property (
    RD_IN && ADDR_IN == 2'h0 |=> (RDATA_OUT & 16'h78f8) == 16'h0000)
    else $error("status spare bits set");
  ctl_zero_a: assert property (
    RD_IN && ADDR_IN != 2'h0 |=> (RDATA_OUT & 16'h1c2c) == 16'h0000)
    else $error("control spare bits set");
  stat_evt_a: assert property (
    RD_IN && ADDR_IN == 2'h0 |=> RDATA_OUT[10:8] == $past(flg_now))
    else $error("event copy mismatch");
  cover property (|TRIGGER_OUT);
  cover property (IDLE_IN && stop_q);
  cover property (RD_IN && ADDR_IN == 2'h0);
endmodule // cmp_event_sva
bind cmp_event_top cmp_event_sva i_cmp_event_sva (.CORE_CLK_IN, .RESET_IN,
  .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .IDLE_IN, .CMP_ENABLE_OUT,
  .RESULT_PIN_OUT, .RESULT_PIN_OE_N_OUT, .TRIGGER_OUT);

// ==== verification/cmp_event_top_tb.sv ====
// Purpose: register-level bench for the comparator control block
// Assumes: read data one cycle after the read strobe
// Notes:   analog results come from the partner model
module cmp_event_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  adr = 2'h0;
  logic [15:0] wd = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        idle = 1'b0;
  logic [15:0] lvl = 16'h5735;
  logic [15:0] rdat, d, w;
  logic [2:0]  en, pref, pin, oen, trig, raw;
  logic [5:0]  nsel;
  logic        x1, x2;
  int          err_total = 0;
  int          comparisons = 0;
  int          ntrig = 0;
  cmp_event_top i_cmp_event_top (.CORE_CLK_IN(clk), .RESET_IN(rst),
    .ADDR_IN(adr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat),
    .IDLE_IN(idle), .RAW_RESULT_IN(raw), .CMP_ENABLE_OUT(en),
    .POS_REF_SELECT_OUT(pref), .NEG_INPUT_SELECT_OUT(nsel),
    .RESULT_PIN_OUT(pin), .RESULT_PIN_OE_N_OUT(oen), .TRIGGER_OUT(trig));
  cmp_analog_model i_cmp_analog_model (.clk_in(clk), .en_in(en),
    .pref_in(pref), .nsel_in(nsel), .lvl_in(lvl), .raw_out(raw));
  initial
    forever #5 clk = ~clk;
  always @(posedge clk)
    if (trig[1])
      ntrig++;
  task automatic wrt(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdt(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      rdt(a[1:0], d);
      chk(16'h0000, d);
    end
    chk(16'h0007, {7'h0, nsel, oen});
    chk(16'h0000, {4'h0, pin, trig, en, pref});
    for (int i = 0; i < 8; i++)
    begin
      w = {2'b11, i[2], 11'h000, i[1:0]};
      x1 = (i[1:0] == 2'h0) ^ i[2];
      wrt(2'h1, w);
      repeat (6) @(posedge clk);
      rdt(2'h1, d);
      chk(w | {7'h0, x1, 8'h00}, d);
      rdt(2'h0, d);
      chk({15'h0, x1}, d);
      chk({14'h0, i[1:0]}, {10'h0, nsel});
      chk({15'h0, x1}, {12'h0, oen[0], pin});
    end
    for (int i = 0; i < 8; i++)
    begin
      w = {2'b10, i[2], 5'h00, i[1:0], 6'h10};
      x1 = i[2] ? i[0] : i[1];
      x2 = i[2] ? i[1] : i[0];
      wrt(2'h2, w);
      repeat (6) @(posedge clk);
      wrt(2'h2, w);
      ntrig = 0;
      lvl[7:4] <= 4'h9;
      repeat (8) @(posedge clk);
      lvl[7:4] <= 4'h3;
      rdt(2'h0, d);
      chk({6'h0, x1, 9'h0}, d & 16'h0200);
      repeat (8) @(posedge clk);
      rdt(2'h0, d);
      chk({6'h0, x1 | x2, 9'h0}, d & 16'hff00);
      chk({15'h0, x1 | x2}, ntrig[15:0]);
      wrt(2'h2, w | 16'h0200);
      rdt(2'h2, d);
      chk({6'h0, x1 | x2, 9'h0}, d & 16'h0200);
      wrt(2'h2, w);
      rdt(2'h2, d);
      chk(16'h0000, d & 16'h0200);
    end
    chk(16'h0002, {13'h0, pref});
    @(posedge clk) idle <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(16'h0003, {13'h0, en});
    wrt(2'h0, 16'hffff);
    #1 chk(16'h0000, {13'h0, en});
    rdt(2'h0, d);
    chk(16'h8000, d & 16'hf8f8);
    @(posedge clk) idle <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(16'h0003, {13'h0, en});
    tally_and_finish;
  end
endmodule // cmp_event_top_tb
